// ===== shared/cef_pkg.sv
// constants for the can error, filter and fifo control block
package cef_pkg;
  localparam int CEF_NFIFO = 32;
  localparam int CEF_NFILT = 4;
  localparam logic [7:0] CEF_OFS_ERRCNT = 8'h00;
  localparam logic [7:0] CEF_OFS_FSTAT = 8'h04;
  localparam logic [7:0] CEF_OFS_FLTCON = 8'h08;
  localparam logic [7:0] CEF_OFS_OPMODE = 8'h0c;
  localparam logic [7:0] CEF_OFS_FIFOCON0 = 8'h80;
  localparam logic [8:0] CEF_BUSOFF_LIM = 9'h100;
  localparam logic [8:0] CEF_PASSIVE_LIM = 9'h080;
  localparam logic [8:0] CEF_WARN_LIM = 9'h060;
  localparam logic [2:0] CEF_MODE_CONFIG = 3'h4;
  localparam logic [2:0] CEF_MODE_RESET = 3'h4;
  localparam int CEF_B_TX_BUS_OFF_FLAG = 21;
  localparam int CEF_B_TX_PASSIVE_FLAG = 20;
  localparam int CEF_B_RX_PASSIVE_FLAG = 19;
  localparam int CEF_B_TX_WARNING_FLAG = 18;
  localparam int CEF_B_RX_WARNING_FLAG = 17;
  localparam int CEF_B_ANY_WARNING_FLAG = 16;
  localparam int CEF_B_FIFO_IS_TRANSMIT = 7;
  localparam int CEF_B_ABAT = 6;
  localparam int CEF_B_LARB = 5;
  localparam int CEF_B_SEND_BUS_ERROR_FLAG = 4;
  localparam int CEF_B_SEND_REQUEST = 3;
  localparam int CEF_B_AUTO_REMOTE_REPLY_ENABLE = 2;
  localparam int CEF_B_FRESET = 14;
  localparam int CEF_B_FLTEN = 7;
  typedef enum logic [1:0] {CEF_IDLE, CEF_SEND} cef_tx_type;
endpackage

// ===== hw/cef_ctrl.sv
// can error counters, filter control and transmit fifo control
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cef_ctrl #(
  parameter int NFIFO = cef_pkg::CEF_NFIFO,
  parameter int NFILT = cef_pkg::CEF_NFILT
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine events
  input wire logic [8:0] tx_error_count,
  input wire logic [7:0] rx_error_count,
  input wire logic [NFIFO-1:0] fifo_irq_src,
  input wire logic tx_done,
  input wire logic tx_aborted,
  input wire logic tx_lost_arb,
  input wire logic tx_bus_err,
  input wire logic tx_fifo_empty,
  input wire logic [NFIFO-1:0] remote_req_rx,
  // engine request and filter configuration
  output logic tx_start,
  output logic [4:0] tx_fifo_sel,
  output logic [8*NFILT-1:0] filter_cfg
);
  import cef_pkg::*;

  if (NFIFO != CEF_NFIFO || NFILT < 1 || NFILT > CEF_NFILT) begin : g_bad_cfg
    $error("cef_ctrl: unsupported fifo or filter count");
  end

  logic [8:0] tec_q;
  logic [7:0] rec_q;
  logic [2:0] controller_op_mode;
  logic [NFIFO-1:0] fifo_irq_pending;
  logic [NFIFO-1:0] send_request, fifo_is_transmit, auto_remote_reply_enable;
  logic [NFIFO-1:0] msg_aborted_flag, lost_arbitration_flag;
  logic [NFIFO-1:0] send_bus_error_flag;
  logic [1:0] send_priority [NFIFO];
  logic [NFILT-1:0] filter_enable;
  logic [1:0] filter_mask_select [NFILT];
  logic [4:0] filter_dest_fifo [NFILT];
  logic tx_bus_off_flag, tx_passive_flag, rx_passive_flag;
  logic tx_warning_flag, rx_warning_flag, any_warning_flag;
  cef_tx_type tx_state;
  logic [4:0] cur_fifo;

  wire logic acc = psel && penable && clk_en;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic fifo_hit = paddr >= CEF_OFS_FIFOCON0;
  wire logic [4:0] fifo_idx = 5'(paddr[6:2]);
  wire logic cfg_mode = controller_op_mode == CEF_MODE_CONFIG;

  // error count capture and state flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
      tx_bus_off_flag <= 1'b0;
      tx_passive_flag <= 1'b0;
      rx_passive_flag <= 1'b0;
      tx_warning_flag <= 1'b0;
      rx_warning_flag <= 1'b0;
      any_warning_flag <= 1'b0;
    end else if (clk_en) begin
      tec_q <= tx_error_count;
      rec_q <= rx_error_count;
      tx_bus_off_flag <= tx_error_count >= CEF_BUSOFF_LIM;
      tx_passive_flag <= tx_error_count >= CEF_PASSIVE_LIM;
      rx_passive_flag <= {1'b0, rx_error_count} >= CEF_PASSIVE_LIM;
      tx_warning_flag <= tx_error_count >= CEF_WARN_LIM &&
                         tx_error_count < CEF_PASSIVE_LIM;
      rx_warning_flag <= {1'b0, rx_error_count} >= CEF_WARN_LIM &&
                         {1'b0, rx_error_count} < CEF_PASSIVE_LIM;
      any_warning_flag <=
        (tx_error_count >= CEF_WARN_LIM &&
         tx_error_count < CEF_PASSIVE_LIM) ||
        ({1'b0, rx_error_count} >= CEF_WARN_LIM &&
         {1'b0, rx_error_count} < CEF_PASSIVE_LIM);
    end
  end

  // pending bits per fifo
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_irq_pending <= '0;
    end else if (clk_en) begin
      fifo_irq_pending <= fifo_irq_src;
    end
  end

  // operating mode register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      controller_op_mode <= CEF_MODE_RESET;
    end else if (wr && paddr == CEF_OFS_OPMODE) begin
      controller_op_mode <= pwdata[2:0];
    end
  end

  // filter control, one byte lane per filter
  genvar gf;
  generate
    for (gf = 0; gf < NFILT; gf++) begin : g_filt
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          filter_enable[gf] <= 1'b0;
          filter_mask_select[gf] <= 2'h0;
          filter_dest_fifo[gf] <= 5'h00;
        end else if (wr && paddr == CEF_OFS_FLTCON) begin
          filter_enable[gf] <= pwdata[8*gf+CEF_B_FLTEN];
          if (!filter_enable[gf]) begin
            filter_mask_select[gf] <= pwdata[8*gf+5 +: 2];
            filter_dest_fifo[gf] <= pwdata[8*gf +: 5];
          end
        end
      end
      assign filter_cfg[8*gf +: 8] = {filter_enable[gf],
        filter_mask_select[gf], filter_dest_fifo[gf]};
      a_filter_lock: assert property (@(posedge mclk) disable iff (sys_rst)
        filter_enable[gf] |=> $stable(filter_dest_fifo[gf]))
        else $error("filter field changed while enabled");
    end
  endgenerate

  // transmit fifo control and status
  genvar gi;
  generate
    for (gi = 0; gi < NFIFO; gi++) begin : g_fifo
      wire logic hit = wr && fifo_hit && fifo_idx == 5'(gi);
      wire logic rhit = rd && fifo_hit && fifo_idx == 5'(gi);
      wire logic frst = hit && pwdata[CEF_B_FRESET];
      wire logic mine = tx_state == CEF_SEND && cur_fifo == 5'(gi)
                        && clk_en;
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          fifo_is_transmit[gi] <= 1'b0;
          auto_remote_reply_enable[gi] <= 1'b0;
          send_priority[gi] <= 2'h0;
        end else if (hit && cfg_mode) begin
          fifo_is_transmit[gi] <= pwdata[CEF_B_FIFO_IS_TRANSMIT];
          auto_remote_reply_enable[gi] <= pwdata[CEF_B_AUTO_REMOTE_REPLY_ENABLE];
          send_priority[gi] <= pwdata[1:0];
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          send_request[gi] <= 1'b0;
        end else if (frst || !fifo_is_transmit[gi]) begin
          send_request[gi] <= 1'b0;
        end else if (clk_en && remote_req_rx[gi] &&
                     auto_remote_reply_enable[gi]) begin
          send_request[gi] <= 1'b1;
        end else if (hit) begin
          send_request[gi] <= pwdata[CEF_B_SEND_REQUEST];
        end else if (mine && (tx_aborted ||
                     (tx_done && tx_fifo_empty))) begin
          send_request[gi] <= 1'b0;
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          msg_aborted_flag[gi] <= 1'b0;
        end else if (mine && tx_aborted) begin
          msg_aborted_flag[gi] <= 1'b1;
        end else if (frst) begin
          msg_aborted_flag[gi] <= 1'b0;
        end else if (mine && tx_done) begin
          msg_aborted_flag[gi] <= 1'b0;
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          lost_arbitration_flag[gi] <= 1'b0;
          send_bus_error_flag[gi] <= 1'b0;
        end else begin
          if (mine && tx_lost_arb) begin
            lost_arbitration_flag[gi] <= 1'b1;
          end else if (rhit || frst) begin
            lost_arbitration_flag[gi] <= 1'b0;
          end
          if (mine && tx_bus_err) begin
            send_bus_error_flag[gi] <= 1'b1;
          end else if (rhit || frst) begin
            send_bus_error_flag[gi] <= 1'b0;
          end
        end
      end
      a_rx_no_req: assert property (@(posedge mclk) disable iff (sys_rst)
        !fifo_is_transmit[gi] |=> !send_request[gi])
        else $error("send request set on receive fifo");
      a_larb_set: assert property (@(posedge mclk) disable iff (sys_rst)
        mine && tx_lost_arb |=> lost_arbitration_flag[gi])
        else $error("lost arbitration not flagged");
      a_read_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        rhit && !(mine && (tx_lost_arb || tx_bus_err)) |=>
        !lost_arbitration_flag[gi] && !send_bus_error_flag[gi])
        else $error("status not cleared by read");
      a_abort_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        mine && tx_aborted && !frst |=> msg_aborted_flag[gi])
        else $error("abort not flagged");
      a_req_done: assert property (@(posedge mclk) disable iff (sys_rst)
        mine && tx_done && tx_fifo_empty && !hit && !remote_req_rx[gi]
        |=> !send_request[gi])
        else $error("send request kept after last send");
      a_remote_set: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && remote_req_rx[gi] && auto_remote_reply_enable[gi] &&
        fifo_is_transmit[gi] && !frst |=> send_request[gi])
        else $error("remote request did not set send request");
    end
  endgenerate

  // arbiter: highest priority, then lowest index
  logic [4:0] next_sel;
  logic next_any;
  logic [1:0] best_pr;
  always_comb begin
    next_sel = 5'h00;
    next_any = 1'b0;
    best_pr = 2'h0;
    for (int i = 0; i < NFIFO; i++) begin
      if (send_request[i] && (!next_any || send_priority[i] > best_pr)) begin
        next_sel = 5'(i);
        best_pr = send_priority[i];
        next_any = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state <= CEF_IDLE;
      cur_fifo <= 5'h00;
      tx_start <= 1'b0;
      tx_fifo_sel <= 5'h00;
    end else if (clk_en) begin
      tx_start <= 1'b0;
      case (tx_state)
        CEF_IDLE: begin
          if (next_any) begin
            tx_state <= CEF_SEND;
            cur_fifo <= next_sel;
            tx_fifo_sel <= next_sel;
            tx_start <= 1'b1;
          end
        end
        CEF_SEND: begin
          if (tx_done || tx_aborted || !send_request[cur_fifo]) begin
            tx_state <= CEF_IDLE;
          end
        end
        default: tx_state <= CEF_IDLE;
      endcase
    end
  end

  a_prio_first: assert property (@(posedge mclk) disable iff (sys_rst)
    tx_start |-> send_priority[tx_fifo_sel] >= $past(best_pr))
    else $error("lower priority fifo started");
  a_busoff: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && tx_error_count >= CEF_BUSOFF_LIM |=> tx_bus_off_flag)
    else $error("bus-off flag missing");
  a_warn_band: assert property (@(posedge mclk) disable iff (sys_rst)
    tx_warning_flag |-> tec_q >= CEF_WARN_LIM && tec_q < CEF_PASSIVE_LIM)
    else $error("tx warning outside band");
  a_rx_warn: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_warning_flag |-> {1'b0, rec_q} >= CEF_WARN_LIM && !rx_passive_flag)
    else $error("rx warning outside band");
  a_tx_passive: assert property (@(posedge mclk) disable iff (sys_rst)
    tx_passive_flag == (tec_q >= CEF_PASSIVE_LIM))
    else $error("tx passive flag mismatch");
  a_rx_passive: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_passive_flag == ({1'b0, rec_q} >= CEF_PASSIVE_LIM))
    else $error("rx passive flag mismatch");
  a_any_warn: assert property (@(posedge mclk) disable iff (sys_rst)
    any_warning_flag == (tx_warning_flag || rx_warning_flag))
    else $error("combined warning mismatch");
  a_cfg_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfg_mode |=> $stable(fifo_is_transmit))
    else $error("config changed outside config mode");

  // apb read mux, zero wait states
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (fifo_hit) begin
      next_rdata[CEF_B_FIFO_IS_TRANSMIT] = fifo_is_transmit[fifo_idx];
      next_rdata[CEF_B_ABAT] = msg_aborted_flag[fifo_idx];
      next_rdata[CEF_B_LARB] = lost_arbitration_flag[fifo_idx];
      next_rdata[CEF_B_SEND_BUS_ERROR_FLAG] = send_bus_error_flag[fifo_idx];
      next_rdata[CEF_B_SEND_REQUEST] = send_request[fifo_idx];
      next_rdata[CEF_B_AUTO_REMOTE_REPLY_ENABLE] = auto_remote_reply_enable[fifo_idx];
      next_rdata[1:0] = send_priority[fifo_idx];
    end else begin
      case (paddr)
        CEF_OFS_ERRCNT: begin
          next_rdata[CEF_B_TX_BUS_OFF_FLAG] = tx_bus_off_flag;
          next_rdata[CEF_B_TX_PASSIVE_FLAG] = tx_passive_flag;
          next_rdata[CEF_B_RX_PASSIVE_FLAG] = rx_passive_flag;
          next_rdata[CEF_B_TX_WARNING_FLAG] = tx_warning_flag;
          next_rdata[CEF_B_RX_WARNING_FLAG] = rx_warning_flag;
          next_rdata[CEF_B_ANY_WARNING_FLAG] = any_warning_flag;
          next_rdata[15:0] = {tec_q[7:0], rec_q};
        end
        CEF_OFS_FSTAT: next_rdata = fifo_irq_pending;
        CEF_OFS_FLTCON: begin
          for (int f = 0; f < NFILT; f++) begin
            next_rdata[8*f +: 8] = {filter_enable[f],
              filter_mask_select[f], filter_dest_fifo[f]};
          end
        end
        CEF_OFS_OPMODE: next_rdata[2:0] = controller_op_mode;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  wire logic mapped = fifo_hit || paddr == CEF_OFS_ERRCNT ||
    paddr == CEF_OFS_FSTAT || paddr == CEF_OFS_FLTCON ||
    paddr == CEF_OFS_OPMODE;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !mapped;
      if (psel && !pwrite && !pready) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/cef_engine_model.sv
// behavioural protocol engine answering each transmit start
`timescale 1ns/10ps
`default_nettype none
module cef_engine_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // start from the controller, outcome and delay from the bench
  input wire logic tx_start,
  input wire logic [1:0] cmd,
  input wire logic [7:0] delay,
  // one-cycle outcome pulses
  output logic tx_done,
  output logic tx_aborted,
  output logic tx_lost_arb,
  output logic tx_bus_err,
  output logic tx_fifo_empty
);
  logic [7:0] left;
  logic busy;
  logic fire;
  assign fire = busy && left == 8'h00;
  // delay counter, outcome taken when it runs out
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      left <= 8'h00;
    end else if (tx_start) begin
      busy <= 1'b1;
      left <= delay;
    end else if (busy && left != 8'h00) begin
      left <= left - 8'h01;
    end else begin
      busy <= 1'b0;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_done <= 1'b0;
      tx_fifo_empty <= 1'b0;
      tx_lost_arb <= 1'b0;
      tx_bus_err <= 1'b0;
      tx_aborted <= 1'b0;
    end else begin
      tx_done <= fire && cmd == 2'h0;
      tx_fifo_empty <= fire && cmd == 2'h0;
      tx_lost_arb <= fire && cmd == 2'h1;
      tx_bus_err <= fire && cmd == 2'h2;
      tx_aborted <= fire && cmd == 2'h3;
    end
  end
endmodule
`default_nettype wire

// ===== bench/can_error_filter_fifo_control_test.sv
// self-checking bench for the error, filter and fifo control block
`timescale 1ns/10ps
`default_nettype none
module can_error_filter_fifo_control_test;
  import cef_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] tx_cnt = 9'h000;
  logic [7:0] rx_cnt = 8'h00;
  logic [31:0] irq_src = 32'h0;
  logic [31:0] rtr = 32'h0;
  logic [1:0] cmd = 2'h0;
  logic [7:0] delay = 8'h03;
  logic [31:0] prdata, rdata, filt;
  logic pready, pslverr, rerr, tx_start, done, abt, larb, berr, empty;
  logic [4:0] sel;
  logic [4:0] sent[$];
  logic [8:0] tv[7] = '{9'h000, 9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff,
                        9'h100};
  logic [7:0] rv[7] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'h00, 8'hff, 8'h60};
  logic [31:0] fw[4] = '{32'h7f205f00, 32'h9fa080e1, 32'h0, 32'h7f205f00};
  logic [31:0] fe[4] = '{32'h7f205f00, 32'h9fa080e1, 32'h1f200061,
                        32'h7f205f00};
  logic [31:0] ev[4] = '{32'h0, 32'h20, 32'h10, 32'h40};
  int err_total = 0;
  int comparisons = 0;
  int cnt;

  always #50 mclk = ~mclk;

  cef_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_error_count(tx_cnt), .rx_error_count(rx_cnt),
    .fifo_irq_src(irq_src), .tx_done(done), .tx_aborted(abt),
    .tx_lost_arb(larb), .tx_bus_err(berr), .tx_fifo_empty(empty),
    .remote_req_rx(rtr), .tx_start(tx_start), .tx_fifo_sel(sel),
    .filter_cfg(filt));

  cef_engine_model u_eng (.mclk(mclk), .sys_rst(sys_rst),
    .tx_start(tx_start), .cmd(cmd), .delay(delay), .tx_done(done),
    .tx_aborted(abt), .tx_lost_arb(larb), .tx_bus_err(berr),
    .tx_fifo_empty(empty));

  always @(posedge mclk) if (tx_start === 1'b1) sent.push_back(sel);

  function automatic logic [31:0] errw(logic [8:0] t, logic [7:0] r);
    logic tw, rw;
    tw = t >= 9'h060 && t < 9'h080;
    rw = r >= 8'h60 && r < 8'h80;
    return {10'h0, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw, tw | rw,
            t[7:0], r};
  endfunction

  function automatic logic [7:0] fo(int n);
    return CEF_OFS_FIFOCON0 + 8'(4 * n);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  // waits for any outcome pulse of the engine
  task automatic reply();
    int n;
    n = 0;
    while ((done | abt | larb | berr) !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) err_total++;
    cmd <= 2'h0;
    @(posedge mclk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(CEF_OFS_ERRCNT, 32'h0);
    rd(CEF_OFS_FLTCON, 32'h0);
    rd(CEF_OFS_OPMODE, 32'h4);
    rd(fo(9), 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      tx_cnt <= tv[i];
      rx_cnt <= rv[i];
      @(posedge mclk);
      rd(CEF_OFS_ERRCNT, errw(tv[i], rv[i]));
    end
    irq_src <= 32'ha5c30f81;
    wr(CEF_OFS_FSTAT, 32'hffffffff);
    rd(CEF_OFS_FSTAT, 32'ha5c30f81);
    $display("test status done");
    for (int i = 0; i < 4; i++) begin
      wr(CEF_OFS_FLTCON, fw[i]);
      rd(CEF_OFS_FLTCON, fe[i]);
      chk(filt, fe[i]);
    end
    $display("test filter done");
    wr(fo(2), 32'h81);
    wr(fo(5), 32'h83);
    wr(fo(9), 32'h84);
    wr(fo(7), 32'h04);
    rd(fo(5), 32'h83);
    wr(CEF_OFS_OPMODE, 32'h0);
    wr(fo(2), 32'h82);
    rd(fo(2), 32'h81);
    delay <= 8'h28;
    wr(fo(9), 32'h8c);
    wr(fo(2), 32'h89);
    wr(fo(5), 32'h8b);
    reply();
    reply();
    reply();
    chk(32'(sent.size()), 32'h3);
    chk({27'h0, sent[1]}, 32'h5);
    chk({27'h0, sent[2]}, 32'h2);
    rd(fo(5), 32'h83);
    rd(fo(2), 32'h81);
    delay <= 8'h03;
    $display("test priority done");
    for (int k = 1; k < 4; k++) begin
      cmd <= 2'(k);
      wr(fo(9), 32'h8c);
      reply();
      wr(fo(9), 32'h84);
      rd(fo(9), 32'h84 | ev[k]);
      rd(fo(9), k == 3 ? 32'hc4 : 32'h84);
    end
    cmd <= 2'h1;
    wr(fo(9), 32'h8c);
    reply();
    wr(fo(9), 32'h4084);
    rd(fo(9), 32'h84);
    wr(fo(9), 32'h8c);
    reply();
    rd(fo(9), 32'h84);
    $display("test outcome done");
    cnt = sent.size();
    en <= 1'b0;
    rtr <= 32'h00000200;
    @(posedge mclk);
    en <= 1'b1;
    rtr <= 32'h0;
    @(posedge mclk);
    rd(fo(9), 32'h84);
    wr(fo(7), 32'h0c);
    rtr <= 32'h00000284;
    @(posedge mclk);
    rtr <= 32'h0;
    reply();
    rd(fo(9), 32'h84);
    chk(32'(sent.size()), 32'(cnt + 1));
    chk({27'h0, sent[$]}, 32'h9);
    $display("test remote done");
    conclude();
  end
endmodule
`default_nettype wire
